/* design/pcs_core.sv */
// Program counter, return stack, peripheral irq and reset-cause registers.
// Assumes the decoder end issues at most one register access and one flow op a cycle.
`timescale 1ns/1ps
`default_nettype none
module pcs_core
    import pcs_pkg::*;
#(
    parameter bit PARITY_VARIANT = 1'b0,
    parameter bit SINGLE_PAGE    = 1'b1
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // Link to decoder
    pcs_if.core       lnk,
    // Interrupt request towards the core sequencer
    output logic      adc_irq_pending
);
    logic [PC_W-1:0] pc_ff, nxt_pc;
    logic [PC_W-1:0] stack_ff [STACK_DEPTH];
    logic [2:0]      sp_ff;
    logic [7:0]      latch_ff, pie_ff, pir_ff, rdata_ff;
    logic [2:0]      cause_ff;         // per, por, bor; 1 = no such reset
    logic            irq_ff;
    logic            cause_seen_ff;

    // Access decode
    wire wr_pcl    = lnk.wr_en && (lnk.addr == ADDR_PCL || lnk.addr == ADDR_PCL_B1);
    wire wr_latch  = lnk.wr_en && (lnk.addr == ADDR_PC_HIGH_LATCH || lnk.addr == ADDR_PC_HIGH_LATCH_B1);
    wire wr_pie    = lnk.wr_en && lnk.addr == ADDR_PIE;
    wire wr_pir    = lnk.wr_en && lnk.addr == ADDR_PIR;
    wire wr_reset_cause_basic   = lnk.wr_en && lnk.addr == ADDR_RESET_CAUSE_BASIC;
    wire do_push   = lnk.op_valid && (lnk.op == PCS_OP_CALL || lnk.op == PCS_OP_IRQ);
    wire do_pop    = lnk.op_valid && lnk.op == PCS_OP_RETURN;
    wire [2:0] sp_top = sp_ff - 3'h1;
    // Page bits are dropped from jump and call targets on a single-page part
    wire [1:0] page = SINGLE_PAGE ? 2'b00 : latch_ff[4:3];
    wire [PC_W-1:0] pc_inc = pc_ff + 13'h0001;

    // Next program counter; a low-byte write wins over flow ops
    always_comb begin
        nxt_pc = pc_inc;
        if (wr_pcl) begin
            nxt_pc = {latch_ff[4:0], lnk.wdata};
        end else if (lnk.op_valid) begin
            case (lnk.op)
                PCS_OP_JUMP, PCS_OP_CALL: nxt_pc = {page, lnk.op_target};
                PCS_OP_RETURN:            nxt_pc = stack_ff[sp_top];
                PCS_OP_IRQ:               nxt_pc = IRQ_VECTOR;
                PCS_OP_HOLD:              nxt_pc = pc_ff;
                default:                  nxt_pc = pc_inc;
            endcase
        end
    end

    // Counter and stack pointer; pointer wraps with no overflow flag
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pc_ff <= PC_RST;
            sp_ff <= 3'h0;
        end else begin
            pc_ff <= nxt_pc;
            if (do_push) sp_ff <= sp_ff + 3'h1;
            else if (do_pop) sp_ff <= sp_top;
        end
    end

    // Stack storage is not reset, as real stack cells
    always_ff @(posedge clk_sys) begin
        if (do_push) stack_ff[sp_ff] <= (lnk.op == PCS_OP_CALL) ? pc_inc : pc_ff;
    end

    // High latch is touched only by software writes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) latch_ff <= PC_HIGH_LATCH_RST;
        else if (wr_latch) latch_ff <= {3'h0, lnk.wdata[4:0]};
    end

    // Peripheral enable and flag; the hardware set wins over a clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pie_ff <= PIE_RST;
            pir_ff <= PIR_RST;
            irq_ff <= 1'b0;
        end else begin
            if (wr_pie) pie_ff <= {1'b0, lnk.wdata[ADC_BIT], 6'h00};
            if (lnk.adc_done) pir_ff[ADC_BIT] <= 1'b1;
            else if (wr_pir) pir_ff[ADC_BIT] <= lnk.wdata[ADC_BIT];
            irq_ff <= pir_ff[ADC_BIT] & pie_ff[ADC_BIT];
        end
    end

    // Reset-cause bits; the cause is captured after release, never as a reset value
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cause_ff      <= 3'b111;
            cause_seen_ff <= 1'b0;
        end else if (lnk.rst_cause_valid && !cause_seen_ff) begin
            cause_seen_ff <= 1'b1;
            case (lnk.rst_cause)
                PCS_RST_POWERON:  cause_ff[1] <= 1'b0;
                PCS_RST_BROWNOUT: cause_ff[0] <= 1'b0;
                PCS_RST_PARITY:   cause_ff[2] <= 1'b0;
                default:          cause_ff    <= cause_ff;
            endcase
        end else if (wr_reset_cause_basic) begin
            cause_ff <= lnk.wdata[2:0];
        end
    end

    // Read data one cycle after the strobe; upper counter bits never appear
    wire [7:0] reset_cause_basic_rd = PARITY_VARIANT ?
                         {lnk.parity_check_enabled, 4'h0, cause_ff} :
                         {6'h00, cause_ff[1:0]};
    wire [7:0] rd_mux  = (lnk.addr == ADDR_PCL || lnk.addr == ADDR_PCL_B1) ? pc_ff[7:0] :
                         (lnk.addr == ADDR_PC_HIGH_LATCH || lnk.addr == ADDR_PC_HIGH_LATCH_B1) ? latch_ff :
                         (lnk.addr == ADDR_PIE) ? pie_ff :
                         (lnk.addr == ADDR_PIR) ? pir_ff :
                         (lnk.addr == ADDR_RESET_CAUSE_BASIC) ? reset_cause_basic_rd : 8'h00;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) rdata_ff <= 8'h00;
        else rdata_ff <= lnk.rd_en ? rd_mux : 8'h00;
    end

    assign lnk.rdata       = rdata_ff;
    assign lnk.pc          = pc_ff;
    assign adc_irq_pending = irq_ff;
endmodule
`default_nettype wire

/* design/pcs_decoder.sv */
// Decoder-side end: turns user flow requests and register accesses into link signals.
// Assumes a user that holds one request per cycle; all link outputs are registered, usr_rdata and usr_pc pass straight through.
`timescale 1ns/1ps
`default_nettype none
module pcs_decoder
    import pcs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // User flow requests
    input  wire logic        usr_op_valid,
    input  wire pcs_op_t     usr_op,
    input  wire logic [10:0] usr_target,
    // User register port
    input  wire logic        usr_wr,
    input  wire logic        usr_rd,
    input  wire logic [8:0]  usr_addr,
    input  wire logic [7:0]  usr_wdata,
    output logic [7:0]       usr_rdata,
    output logic [12:0]      usr_pc,
    // Event and reset sources
    input  wire logic        usr_adc_done,
    input  wire logic        usr_cause_valid,
    input  wire pcs_cause_t  usr_cause,
    input  wire logic        usr_parity_en,
    // Link to core
    pcs_if.decoder           lnk
);
    logic       op_valid_ff, wr_ff, rd_ff, adc_ff, cv_ff, pe_ff;
    pcs_op_t    op_ff;
    logic [10:0] tgt_ff;
    logic [8:0] addr_ff;
    logic [7:0] wdata_ff;
    pcs_cause_t cause_ff;

    // One register stage on every request; software keeps flag/enable order
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            op_valid_ff <= 1'b0;
            op_ff       <= PCS_OP_STEP;
            tgt_ff      <= 11'h000;
            wr_ff       <= 1'b0;
            rd_ff       <= 1'b0;
            addr_ff     <= 9'h000;
            wdata_ff    <= 8'h00;
            adc_ff      <= 1'b0;
            cv_ff       <= 1'b0;
            cause_ff    <= PCS_RST_OTHER;
            pe_ff       <= 1'b0;
        end else begin
            op_valid_ff <= usr_op_valid;
            op_ff       <= usr_op;
            tgt_ff      <= usr_target;
            wr_ff       <= usr_wr;
            rd_ff       <= usr_rd && !usr_wr;
            addr_ff     <= usr_addr;
            wdata_ff    <= usr_wdata;
            adc_ff      <= usr_adc_done;
            cv_ff       <= usr_cause_valid;
            cause_ff    <= usr_cause;
            pe_ff       <= usr_parity_en;
        end
    end

    assign lnk.op_valid             = op_valid_ff;
    assign lnk.op                   = op_ff;
    assign lnk.op_target            = tgt_ff;
    assign lnk.wr_en                = wr_ff;
    assign lnk.rd_en                = rd_ff;
    assign lnk.addr                 = addr_ff;
    assign lnk.wdata                = wdata_ff;
    assign lnk.adc_done             = adc_ff;
    assign lnk.rst_cause_valid      = cv_ff;
    assign lnk.rst_cause            = cause_ff;
    assign lnk.parity_check_enabled = pe_ff;
    assign usr_rdata                = lnk.rdata;
    assign usr_pc                   = lnk.pc;
endmodule
`default_nettype wire

/* design/pcs_if.sv */
// Link between the instruction decoder end and the program-counter core end.
// Assumes both ends run on the one core clock.
`timescale 1ns/1ps
`default_nettype none
interface pcs_if
    import pcs_pkg::*;
    (input wire logic clk_sys);
    logic             op_valid;
    pcs_op_t          op;
    logic [10:0]      op_target;
    logic             wr_en;
    logic             rd_en;
    logic [8:0]       addr;
    logic [7:0]       wdata;
    logic [7:0]       rdata;
    logic [12:0]      pc;
    logic             adc_done;
    logic             rst_cause_valid;
    pcs_cause_t       rst_cause;
    logic             parity_check_enabled;
    modport core (input op_valid, op, op_target, wr_en, rd_en, addr, wdata, adc_done,
                  rst_cause_valid, rst_cause, parity_check_enabled, output rdata, pc);
    modport decoder (output op_valid, op, op_target, wr_en, rd_en, addr, wdata, adc_done,
                     rst_cause_valid, rst_cause, parity_check_enabled, input rdata, pc);
endinterface
`default_nettype wire

/* design/pcs_pkg.sv */
// Package for the program-counter, return-stack and reset-cause block.
// Assumes one core clock shared by both ends; no timing constants are needed.
package pcs_pkg;
    localparam int          PC_W          = 13;
    localparam int          STACK_DEPTH   = 8;
    localparam int          PAGE_LSB      = 11;
    // Register offsets (byte addresses of the 8-bit file)
    localparam logic [8:0]  ADDR_PCL      = 9'h002;
    localparam logic [8:0]  ADDR_PCL_B1   = 9'h082;
    localparam logic [8:0]  ADDR_PC_HIGH_LATCH   = 9'h00a;
    localparam logic [8:0]  ADDR_PC_HIGH_LATCH_B1 = 9'h08a;
    localparam logic [8:0]  ADDR_PIR      = 9'h00c;
    localparam logic [8:0]  ADDR_PIE      = 9'h08c;
    localparam logic [8:0]  ADDR_RESET_CAUSE_BASIC     = 9'h08e;
    // Field positions
    localparam int          ADC_BIT       = 6;
    localparam int          BOR_BIT       = 0;
    localparam int          POR_BIT       = 1;
    localparam int          PER_BIT       = 2;
    localparam int          PARITY_CHECK_ENABLED_BIT     = 7;
    // Reset values
    localparam logic [7:0]  PIR_RST       = 8'h00;
    localparam logic [7:0]  PIE_RST       = 8'h00;
    localparam logic [7:0]  PC_HIGH_LATCH_RST    = 8'h00;
    localparam logic [12:0] PC_RST        = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR    = 13'h0004;
    // Reset causes reported by the reset controller
    typedef enum logic [1:0] {
        PCS_RST_OTHER,
        PCS_RST_POWERON,
        PCS_RST_BROWNOUT,
        PCS_RST_PARITY
    } pcs_cause_t;
    // Program-flow operations issued by the decoder
    typedef enum logic [2:0] {
        PCS_OP_STEP,
        PCS_OP_JUMP,
        PCS_OP_CALL,
        PCS_OP_RETURN,
        PCS_OP_IRQ,
        PCS_OP_HOLD
    } pcs_op_t;
endpackage

/* tb/pc_stack_reset_status_bench.sv */
// Bench joining the decoder and core ends over the link, self-checking.
// Assumes the basic status layout and a single program page.
`timescale 1ns/1ps
`default_nettype none
module pc_stack_reset_status_bench
    import pcs_pkg::*;
;
    logic        clk_sys = 1'b0, resetn = 1'b0, op_v = 1'b1, wr = 1'b0, rd = 1'b0;
    logic        adc = 1'b0, cv = 1'b0, pc_chk = 1'b0, irq;
    pcs_op_t     op = PCS_OP_HOLD;
    pcs_cause_t  cause = PCS_RST_OTHER;
    logic [10:0] tgt = 11'h000;
    logic [8:0]  addr = 9'h000;
    logic [7:0]  wd = 8'h00, rdata;
    logic [12:0] pc, m_pc, stk [8];
    logic [2:0]  sp = 3'h0;
    logic [1:0]  rd_p = 2'b00;
    logic [13:0] exp_q [$];
    logic [31:0] seed = 32'he263;
    int          bad_count = 0, check_count = 0, cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    pcs_if lnk (.clk_sys(clk_sys));
    pcs_decoder i_pcs_decoder (.clk_sys(clk_sys), .resetn(resetn), .usr_op_valid(op_v), .usr_op(op),
        .usr_target(tgt), .usr_wr(wr), .usr_rd(rd), .usr_addr(addr), .usr_wdata(wd), .usr_rdata(rdata),
        .usr_pc(pc), .usr_adc_done(adc), .usr_cause_valid(cv), .usr_cause(cause), .usr_parity_en(1'b0), .lnk(lnk));
    pcs_core i_pcs_core (.clk_sys(clk_sys), .resetn(resetn), .lnk(lnk), .adc_irq_pending(irq));
    pcs_chk i_pcs_chk (.clk_sys(clk_sys), .resetn(resetn), .op_valid(lnk.op_valid), .op(lnk.op),
        .op_target(lnk.op_target), .wr_en(lnk.wr_en), .rd_en(lnk.rd_en), .addr(lnk.addr), .wdata(lnk.wdata),
        .rdata(lnk.rdata), .pc(lnk.pc), .adc_done(lnk.adc_done));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic check(input logic [13:0] seen, input logic [13:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Monitor: read data lands two edges after the strobe; pc is taken once settled
    always @(posedge clk_sys) begin
        rd_p <= {rd_p[0], rd};
        if (rd_p[1])
            check({6'h00, rdata}, exp_q.pop_front());
        if (pc_chk)
            check({irq, pc}, exp_q.pop_front());
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end
    // Let any read already in the pipe land before the reset wipes the read data
    task automatic do_reset();
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
    endtask
    // One bus cycle; for a read, d is the value expected back
    task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        adc <= 1'b0;
        wr <= w;
        rd <= !w;
        addr <= a;
        wd <= d;
        if (!w)
            exp_q.push_back({6'h00, d});
        @(posedge clk_sys);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // Pc is held still between ops, so any pass-through delay has run out here
    task automatic settle(input logic i);
        repeat (3) @(posedge clk_sys);
        exp_q.push_back({i, m_pc});
        pc_chk <= 1'b1;
        @(posedge clk_sys);
        pc_chk <= 1'b0;
    endtask
    // One flow op with a circular stack model; an empty pop just wraps
    task automatic flow(input pcs_op_t o, input logic [10:0] t, input logic v);
        @(posedge clk_sys);
        op_v <= v;
        op <= o;
        tgt <= t;
        if (!v || o == PCS_OP_STEP)
            m_pc = m_pc + 13'h0001;
        else if (o == PCS_OP_JUMP)
            m_pc = {2'b00, t};
        else if (o == PCS_OP_RETURN) begin
            sp = sp - 3'h1;
            m_pc = stk[sp];
        end else begin
            stk[sp] = (o == PCS_OP_CALL) ? m_pc + 13'h0001 : m_pc;
            sp = sp + 3'h1;
            m_pc = (o == PCS_OP_CALL) ? {2'b00, t} : IRQ_VECTOR;
        end
        @(posedge clk_sys);
        op_v <= 1'b1;
        op <= PCS_OP_HOLD;
        settle(1'b0);
    endtask
    // Main sequence
    initial begin
        for (int i = 0; i < 4; i++) begin
            do_reset();
            @(posedge clk_sys);
            cv <= 1'b1;
            cause <= pcs_cause_t'(i);
            @(posedge clk_sys);
            cv <= 1'b0;
            bus(1'b0, ADDR_RESET_CAUSE_BASIC, i == 1 ? 8'h01 : i == 2 ? 8'h02 : 8'h03);
        end
        bus(1'b1, ADDR_RESET_CAUSE_BASIC, 8'hfc);
        bus(1'b0, ADDR_RESET_CAUSE_BASIC, 8'h00);
        bus(1'b0, ADDR_PIE, 8'h00);
        bus(1'b0, ADDR_PIR, 8'h00);
        adc <= 1'b1;
        bus(1'b0, ADDR_PIR, 8'h40);
        bus(1'b1, ADDR_PIR, 8'h00);
        bus(1'b1, ADDR_PIE, 8'hff);
        adc <= 1'b1;
        bus(1'b0, ADDR_PIE, 8'h40);
        bus(1'b1, ADDR_PC_HIGH_LATCH_B1, 8'hff);
        bus(1'b1, ADDR_PCL, 8'h34);
        m_pc = 13'h1f34;
        settle(1'b1);
        bus(1'b1, ADDR_PIR, 8'h00);
        bus(1'b0, ADDR_PIR, 8'h00);
        bus(1'b0, ADDR_PCL_B1, 8'h34);
        for (int i = 0; i < 10; i++)
            flow(PCS_OP_CALL, 11'(i * 100), 1'b1);
        for (int i = 0; i < 10; i++)
            flow(PCS_OP_RETURN, 11'h000, 1'b1);
        flow(PCS_OP_JUMP, 11'h7ff, 1'b1);
        flow(PCS_OP_STEP, 11'h000, 1'b0);
        // Call directly followed by return: the pushed address comes straight back
        @(posedge clk_sys);
        op <= PCS_OP_CALL;
        tgt <= 11'h123;
        @(posedge clk_sys);
        op <= PCS_OP_RETURN;
        @(posedge clk_sys);
        op <= PCS_OP_HOLD;
        stk[sp] = m_pc + 13'h0001;
        m_pc = m_pc + 13'h0001;
        settle(1'b0);
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            flow(pcs_op_t'(3'(seed % 5)), seed[26:16], seed[31]);
        end
        bus(1'b0, ADDR_PCL, 8'(m_pc));
        bus(1'b0, ADDR_PC_HIGH_LATCH, 8'h1f);
        repeat (4) @(posedge clk_sys);
        end_sim();
    end
endmodule
`default_nettype wire

/* tb/pcs_chk.sv */
// Link checker for the program-counter, return-stack and status block.
// Assumes the core's basic status layout and a single program page.
`timescale 1ns/1ps
`default_nettype none
module pcs_chk
    import pcs_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // Link signals
    input wire logic        op_valid,
    input wire pcs_op_t     op,
    input wire logic [10:0] op_target,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [8:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic [7:0]  rdata,
    input wire logic [12:0] pc,
    input wire logic        adc_done
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // A low-byte write beats any flow op, so flow checks skip those cycles
    wire lo_wr = wr_en && (addr == ADDR_PCL || addr == ADDR_PCL_B1);
    wire fl    = op_valid && !lo_wr;
    wire rd_ok = rd_en && !wr_en;
    // Single-step and multi-step behaviours
    sequence s_call; fl && op == PCS_OP_CALL; endsequence
    sequence s_ret; fl && op == PCS_OP_RETURN; endsequence
    sequence s_done_rd; adc_done ##1 (rd_ok && addr == ADDR_PIR); endsequence
    property p_step; fl && op == PCS_OP_STEP |=> pc == $past(pc) + 13'h0001; endproperty
    a_step: assert property (p_step) else $error("pc did not step");
    property p_jump; fl && op inside {PCS_OP_JUMP, PCS_OP_CALL} |=> pc == {2'b00, $past(op_target)}; endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");
    property p_irq; fl && op == PCS_OP_IRQ |=> pc == IRQ_VECTOR; endproperty
    a_irq: assert property (p_irq) else $error("no vector on irq");
    property p_callret; s_call ##1 s_ret |=> pc == $past(pc, 2) + 13'h0001; endproperty
    a_callret: assert property (p_callret) else $error("return address wrong");
    property p_lowwr; lo_wr |=> pc[7:0] == $past(wdata); endproperty
    a_lowwr: assert property (p_lowwr) else $error("low byte not loaded");
    property p_pie; rd_ok && addr == ADDR_PIE |=> (rdata & 8'hbf) == 8'h00; endproperty
    a_pie: assert property (p_pie) else $error("enable spare bits set");
    property p_cause; rd_ok && addr == ADDR_RESET_CAUSE_BASIC |=> rdata[7:2] == 6'h00; endproperty
    a_cause: assert property (p_cause) else $error("status spare bits set");
    property p_flag; s_done_rd |=> rdata == 8'h40; endproperty
    a_flag: assert property (p_flag) else $error("done flag not set");
endmodule
`default_nettype wire
